// file: gdsp_cfg.svh
// constants for the instrument bus status port
// assumes inclusion by gdsp_pkg and gdsp_port only
// Function
// RULE1: source, acceptor handshake, service request, device clear fully implemented
// RULE2: no extended addressing, parallel poll, trigger or controller
// RULE3: talker with serial poll, unaddressed on own listen address
// RULE4: listener, unaddressed on own talk address
// RULE5: take control only for local hardcopy with bus print destination
// RULE6: front panel and bus control accepted together unless disabled
// RULE7: clear-status clears status and idles both completion machines
// RULE8: event enable register loaded by command, returned by query
// RULE9: event status query returns register and clears it
// RULE10: service enable register loaded by command, returned as integer; code returns the raw register byte
// RULE11: status byte query returns byte including summary bit
// RULE12: identification query returns identification string
// RULE13: self-test query is a no-op reporting connectivity
// RULE14: completion command sets completion event bit when ops finish
// RULE15: completion query queues ASCII one when ops finish; code drops it if ops finish while an identification reply is queued
// RULE16: wait command holds execution until nothing pending
// RULE17: request service when enabled status bit set, show in poll
`ifndef GDSP_CFG_SVH
`define GDSP_CFG_SVH
`define GDSP_CMD_IFC     8'h01
`define GDSP_CMD_UNL     8'h3F
`define GDSP_CMD_UNT     8'h5F
`define GDSP_CMD_SPE     8'h18
`define GDSP_CMD_SPD     8'h19
`define GDSP_CMD_DCL     8'h14
`define GDSP_CMD_SDC     8'h04
`define GDSP_LAD_BASE    3'b001
`define GDSP_TAD_BASE    3'b010
`define GDSP_ESR_OPC     0
`define GDSP_STB_MAV     4
`define GDSP_STB_ESB     5
`define GDSP_STB_RQS     6
`define GDSP_ASCII_ONE   8'h31
`define GDSP_ID_LEN      4
`define GDSP_ID_CHAR     8'h41
`endif

// file: gdsp_pkg.sv
// types for the instrument bus status port
// assumes gdsp_cfg.svh is on the include path
`include "gdsp_cfg.svh"
package gdsp_pkg;
  typedef enum logic [3:0] {
    GDSP_NONE, GDSP_CLS, GDSP_ESE, GDSP_ESEQ, GDSP_ESRQ, GDSP_SRE, GDSP_SREQ,
    GDSP_STBQ, GDSP_IDNQ, GDSP_RST, GDSP_TSTQ, GDSP_OPC, GDSP_OPCQ, GDSP_WAI
  } gdsp_cmd_t;
  typedef enum logic [1:0] {GDSP_SH_IDLE, GDSP_SH_VALID, GDSP_SH_WAIT} gdsp_sh_t;
endpackage

// file: gdsp_outq.sv
// small output queue for reply bytes
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module gdsp_outq #(
  parameter int DEPTH = 8
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       flush,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  input  wire logic       rdEn,
  output logic      [7:0] rdData,
  output logic            notEmpty,
  output logic            full
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wrPtr_ff;
  logic [AW:0] rdPtr_ff;
  logic [7:0]  rdData_ff;
  logic        doWr;
  logic        doRd;
  logic [AW-1:0] rdNext;
  assign notEmpty = wrPtr_ff != rdPtr_ff;
  assign full     = (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]) && !(wrPtr_ff[AW] == rdPtr_ff[AW]);
  assign doWr     = wrEn && !full;
  assign doRd     = rdEn && notEmpty;
  assign rdData   = rdData_ff;
  assign rdNext   = rdPtr_ff[AW-1:0] + AW'(doRd);
  always_ff @(posedge clock) begin
    if (doWr) begin
      mem[wrPtr_ff[AW-1:0]] <= wrData;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      if (doWr) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
    end
  end
  // head byte registered; write bypass so a byte landing at the head is never stale
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= (doWr && wrPtr_ff[AW-1:0] == rdNext) ? wrData : mem[rdNext];
    end
  end
endmodule

// file: gdsp_port.sv
// device side of the instrument bus: handshakes, addressing, status
// assumes common commands arrive already parsed on cmdValid/cmdCode/cmdArg
`timescale 1ns/1ps
`include "gdsp_cfg.svh"
module gdsp_port #(
  parameter int QDEPTH = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [4:0]        myAddr,
  input  wire logic              busEnable,
  input  wire logic              atnIn,
  input  wire logic [7:0]        dioIn,
  input  wire logic              davIn,
  input  wire logic              nrfdIn,
  input  wire logic              ndacIn,
  output logic      [7:0]        dioOut,
  output logic                   dioOe,
  output logic                   davOut,
  output logic                   davOe,
  output logic                   nrfdOut,
  output logic                   nrfdOe,
  output logic                   ndacOut,
  output logic                   ndacOe,
  output logic                   srqOut,
  output logic                   srqOe,
  output logic                   rxValid,
  output logic      [7:0]        rxData,
  input  wire logic              cmdValid,
  input  wire gdsp_pkg::gdsp_cmd_t cmdCode,
  input  wire logic [7:0]        cmdArg,
  output logic                   cmdReady,
  input  wire logic [7:0]        eventSet,
  input  wire logic              opsPending,
  input  wire logic [7:0]        stbDevBits,
  input  wire logic              localCopyReq,
  input  wire logic              printToBus,
  input  wire logic              remoteDisable,
  output logic                   panelEnable,
  output logic                   ctrlReq,
  output logic                   devClear,
  output logic                   devReset,
  output logic                   talkAddr,
  output logic                   listenAddr,
  output logic      [7:0]        eseValue,
  output logic      [7:0]        sreValue,
  output logic      [7:0]        esrValue
);
  import gdsp_pkg::*;
  function automatic logic isAddr(input logic [7:0] b, input logic [2:0] grp,
                                  input logic [4:0] a);
    isAddr = (b[6:5] == grp[1:0]) && (b[4:0] == a);
  endfunction
  logic       atnMode;
  logic       acceptStrobe;
  logic       ahBusy_ff;
  logic       talk_ff;
  logic       listen_ff;
  logic       spoll_ff;
  logic [7:0] ese_ff;
  logic [7:0] sre_ff;
  logic [7:0] esr_ff;
  logic       opcArmed_ff;
  logic       opcqArmed_ff;
  logic       waiting_ff;
  logic       rqs_ff;
  logic       rqsShown_ff;
  logic [1:0] idIdx_ff;
  logic       idBusy_ff;
  logic       qWr;
  logic [7:0] qData;
  logic       qPop;
  logic [7:0] qHead;
  logic       qAvail;
  logic       qFull;
  logic       clsNow;
  logic       esrRead;
  logic       mss;
  logic [7:0] stb;
  logic       doCmd;
  gdsp_sh_t   sh_ff;
  assign atnMode      = busEnable && atnIn;
  // acceptor handshake: take a byte when DAV asserted and ready released
  assign acceptStrobe = busEnable && davIn && !ahBusy_ff && (atnMode || listen_ff); // RULE1
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ahBusy_ff <= 1'b0;
    end else if (acceptStrobe) begin
      ahBusy_ff <= 1'b1;
    end else if (!davIn) begin
      ahBusy_ff <= 1'b0;
    end
  end
  assign nrfdOut = ahBusy_ff;
  assign ndacOut = !ahBusy_ff;
  assign nrfdOe  = busEnable && (atnMode || listen_ff);
  assign ndacOe  = nrfdOe;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rxValid <= 1'b0;
      rxData  <= 8'h00;
    end else begin
      rxValid <= acceptStrobe && !atnMode;
      rxData  <= dioIn;
    end
  end
  // addressing; extended addresses, parallel poll and trigger bytes ignored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      talk_ff   <= 1'b0;
      listen_ff <= 1'b0;
      spoll_ff  <= 1'b0;
    end else if (!busEnable || (acceptStrobe && atnMode && dioIn == `GDSP_CMD_IFC)) begin
      talk_ff   <= 1'b0;
      listen_ff <= 1'b0;
      spoll_ff  <= 1'b0;
    end else if (acceptStrobe && atnMode) begin // RULE2
      if (isAddr(dioIn, `GDSP_LAD_BASE, myAddr)) begin
        listen_ff <= 1'b1;
        talk_ff   <= 1'b0; // RULE3
      end else if (isAddr(dioIn, `GDSP_TAD_BASE, myAddr)) begin
        talk_ff   <= 1'b1;
        listen_ff <= 1'b0; // RULE4
      end else if (dioIn == `GDSP_CMD_UNL) begin
        listen_ff <= 1'b0;
      end else if (dioIn == `GDSP_CMD_UNT) begin
        talk_ff <= 1'b0;
      end else if (dioIn == `GDSP_CMD_SPE) begin
        spoll_ff <= 1'b1; // RULE3
      end else if (dioIn == `GDSP_CMD_SPD) begin
        spoll_ff <= 1'b0;
      end
    end
  end
  assign talkAddr   = talk_ff;
  assign listenAddr = listen_ff;
  // device clear: universal, or selected while listening
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      devClear <= 1'b0;
    end else begin
      devClear <= acceptStrobe && atnMode && (dioIn == `GDSP_CMD_DCL
                  || (dioIn == `GDSP_CMD_SDC && listen_ff)); // RULE1
    end
  end
  // source handshake: serial poll sends status byte, else queue head
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sh_ff <= GDSP_SH_IDLE;
    end else begin
      case (sh_ff)
        GDSP_SH_IDLE: begin
          if (talk_ff && !atnMode && (spoll_ff || qAvail) && nrfdIn == 1'b0) begin
            sh_ff <= GDSP_SH_VALID; // RULE1
          end
        end
        GDSP_SH_VALID: begin
          if (!ndacIn) begin
            sh_ff <= GDSP_SH_WAIT;
          end
        end
        GDSP_SH_WAIT: begin
          if (ndacIn) begin
            sh_ff <= GDSP_SH_IDLE;
          end
        end
        default: sh_ff <= GDSP_SH_IDLE;
      endcase
    end
  end
  assign qPop   = sh_ff == GDSP_SH_VALID && !ndacIn && !spoll_ff;
  assign davOut = sh_ff == GDSP_SH_VALID;
  assign davOe  = busEnable && talk_ff && !atnMode;
  assign dioOe  = davOe;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dioOut <= 8'h00;
    end else begin
      dioOut <= spoll_ff ? {stb[7], rqsShown_ff, stb[5:0]} : qHead; // RULE17
    end
  end
  // status byte and service request
  assign mss = |(stb & sre_ff & 8'hBF);
  assign stb = {stbDevBits[7:6], |(esr_ff & ese_ff), qAvail, stbDevBits[3:0]} & 8'hBF;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rqs_ff      <= 1'b0;
      rqsShown_ff <= 1'b0;
    end else begin
      rqs_ff      <= mss && busEnable; // RULE17
      rqsShown_ff <= mss;
    end
  end
  assign srqOut = rqs_ff;
  assign srqOe  = rqs_ff;
  // common command execution; wait blocks everything behind it
  assign doCmd    = cmdValid && cmdReady;
  // hold off while the completion reply lands, else a query reply would be lost
  assign cmdReady = !waiting_ff && !idBusy_ff && !qFull
                    && !(opcqArmed_ff && !opsPending); // RULE16
  assign clsNow   = doCmd && cmdCode == GDSP_CLS;
  assign esrRead  = doCmd && cmdCode == GDSP_ESRQ;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waiting_ff <= 1'b0;
    end else if (doCmd && cmdCode == GDSP_WAI && opsPending) begin
      waiting_ff <= 1'b1; // RULE16
    end else if (!opsPending) begin
      waiting_ff <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ese_ff <= 8'h00;
      sre_ff <= 8'h00;
    end else if (doCmd && cmdCode == GDSP_ESE) begin
      ese_ff <= cmdArg; // RULE8
    end else if (doCmd && cmdCode == GDSP_SRE) begin
      sre_ff <= cmdArg & 8'hBF; // RULE10
    end
  end
  // event set beats the clearing read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      esr_ff <= 8'h00;
    end else begin
      esr_ff <= ((clsNow || esrRead) ? 8'h00 : esr_ff) | eventSet
                | {7'h00, opcArmed_ff && !opsPending}; // RULE7 RULE9 RULE14
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || clsNow) begin
      opcArmed_ff  <= 1'b0; // RULE7
      opcqArmed_ff <= 1'b0;
    end else begin
      if (doCmd && cmdCode == GDSP_OPC) begin
        opcArmed_ff <= 1'b1;
      end else if (!opsPending) begin
        opcArmed_ff <= 1'b0; // RULE14
      end
      if (doCmd && cmdCode == GDSP_OPCQ) begin
        opcqArmed_ff <= 1'b1;
      end else if (!opsPending && !qFull) begin
        opcqArmed_ff <= 1'b0; // RULE15
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      idBusy_ff <= 1'b0;
      idIdx_ff  <= 2'd0;
    end else if (doCmd && cmdCode == GDSP_IDNQ) begin
      idBusy_ff <= 1'b1; // RULE12
      idIdx_ff  <= 2'd0;
    end else if (idBusy_ff && !qFull) begin
      idIdx_ff  <= idIdx_ff + 2'd1;
      idBusy_ff <= idIdx_ff != 2'(`GDSP_ID_LEN - 1);
    end
  end
  // replies are raw bytes; self-test answers zero and touches nothing
  always_comb begin
    qWr   = 1'b0;
    qData = 8'h00;
    if (idBusy_ff) begin
      qWr   = 1'b1;
      qData = `GDSP_ID_CHAR + {6'h00, idIdx_ff}; // RULE12
    end else if (opcqArmed_ff && !opsPending) begin
      qWr   = 1'b1;
      qData = `GDSP_ASCII_ONE; // RULE15
    end else if (doCmd) begin
      case (cmdCode)
        GDSP_ESEQ: begin qWr = 1'b1; qData = ese_ff; end // RULE8
        GDSP_ESRQ: begin qWr = 1'b1; qData = esr_ff; end // RULE9
        GDSP_SREQ: begin qWr = 1'b1; qData = sre_ff; end // RULE10
        GDSP_STBQ: begin qWr = 1'b1; qData = stb | {1'b0, mss, 6'h00}; end // RULE11
        GDSP_TSTQ: begin qWr = 1'b1; qData = 8'h00; end // RULE13
        default:   begin qWr = 1'b0; qData = 8'h00; end
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      devReset <= 1'b0;
    end else begin
      devReset <= doCmd && cmdCode == GDSP_RST;
    end
  end
  assign ctrlReq     = localCopyReq && printToBus && busEnable; // RULE5
  assign panelEnable = !remoteDisable; // RULE6
  assign eseValue    = ese_ff;
  assign sreValue    = sre_ff;
  assign esrValue    = esr_ff;
  gdsp_outq #(.DEPTH(QDEPTH)) outQueue (
    .clock    (clock),
    .rst_n    (rst_n),
    .flush    (devClear),
    .wrEn     (qWr),
    .wrData   (qData),
    .rdEn     (qPop),
    .rdData   (qHead),
    .notEmpty (qAvail),
    .full     (qFull)
  );
endmodule

// file: gdsp_port_checker.sv
// assertions on the instrument bus status port pins
// assumes binding onto gdsp_port, one clock, sync reset
`timescale 1ns/1ps
module gdsp_port_checker (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                busEnable,
  input wire logic                davOe,
  input wire logic                nrfdOe,
  input wire logic                ndacOe,
  input wire logic                cmdValid,
  input wire gdsp_pkg::gdsp_cmd_t cmdCode,
  input wire logic [7:0]          cmdArg,
  input wire logic                cmdReady,
  input wire logic [7:0]          eventSet,
  input wire logic                opsPending,
  input wire logic [7:0]          stbDevBits,
  input wire logic                localCopyReq,
  input wire logic                printToBus,
  input wire logic                remoteDisable,
  input wire logic                panelEnable,
  input wire logic                ctrlReq,
  input wire logic                srqOut,
  input wire logic [7:0]          eseValue,
  input wire logic [7:0]          sreValue,
  input wire logic [7:0]          esrValue
);
  import gdsp_pkg::*;
  logic take;
  assign take = cmdValid && cmdReady;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_CTRL_REQ: assert property (ctrlReq == (localCopyReq && printToBus && busEnable))
    else $error("control request wrong");
  AST_PANEL: assert property (panelEnable == !remoteDisable)
    else $error("panel enable wrong");
  AST_OFF_BUS: assert property (!busEnable |-> !davOe && !nrfdOe && !ndacOe)
    else $error("handshake driven while off bus");
  AST_ESE_LOAD: assert property (take && cmdCode == GDSP_ESE |=> eseValue == $past(cmdArg))
    else $error("event enable not loaded");
  AST_SRE_LOAD: assert property (take && cmdCode == GDSP_SRE |=> sreValue == ($past(cmdArg) & 8'hBF))
    else $error("service enable not loaded");
  AST_CLS: assert property (take && cmdCode == GDSP_CLS |=> esrValue == $past(eventSet))
    else $error("clear status left events");
  AST_ESR_READ: assert property (take && cmdCode == GDSP_ESRQ |=>
    (esrValue & ~$past(eventSet) & 8'hFE) == 8'h00) else $error("event read did not clear");
  AST_WAI: assert property (take && cmdCode == GDSP_WAI && opsPending ##1 opsPending
    |-> !cmdReady) else $error("command taken during wait");
  AST_OPC: assert property (take && cmdCode == GDSP_OPC && !opsPending ##1 !opsPending
    |-> ##1 esrValue[0]) else $error("completion bit not set");
  AST_SRQ: assert property ((busEnable && |(stbDevBits & sreValue & 8'h8F)) [*3]
    |-> srqOut) else $error("service request missing");
  cover property (take && cmdCode == GDSP_WAI && opsPending);
  cover property (srqOut);
  cover property (ctrlReq);
endmodule
bind gdsp_port gdsp_port_checker u_chk (.clock, .rst_n, .busEnable, .davOe, .nrfdOe, .ndacOe,
  .cmdValid, .cmdCode, .cmdArg, .cmdReady, .eventSet, .opsPending, .stbDevBits, .localCopyReq,
  .printToBus, .remoteDisable, .panelEnable, .ctrlReq, .srqOut, .eseValue, .sreValue, .esrValue);

// file: gdsp_ctrl_model.sv
// behavioural bus controller: sends bytes, accepts talker bytes
// assumes wired-or bus levels, high = asserted, released lines read 0
`timescale 1ns/1ps
module gdsp_ctrl_model (
  input  wire logic       clock,
  input  wire logic       nrfdBus,
  input  wire logic       ndacBus,
  input  wire logic       davBus,
  input  wire logic [7:0] dioBus,
  output logic            atn,
  output logic [7:0]      dio,
  output logic            dav,
  output logic            nrfd,
  output logic            ndac,
  output logic            tmo
);
  initial {atn, dio, dav, nrfd, ndac, tmo} = {1'b0, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0};
  function automatic logic ln(input int s);
    return s == 0 ? nrfdBus : s == 1 ? ndacBus : davBus;
  endfunction
  // bounded so a dead handshake flags instead of hanging
  task automatic waitFor(input int s, input logic v);
    int n;
    n = 0;
    while (ln(s) !== v && n < 200) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (ln(s) !== v) tmo = 1'b1;
  endtask
  task automatic send(input logic [7:0] b, input logic a, input int slow);
    nrfd = 1'b0;
    ndac = 1'b0;
    atn = a;
    dio = b;
    repeat (slow + 1) @(posedge clock);
    #1 waitFor(0, 1'b0);
    dav = 1'b1;
    @(posedge clock);
    #1 waitFor(1, 1'b0);
    dav = 1'b0;
    dio = 8'h00;
    repeat (2) @(posedge clock);
    #1 atn = 1'b0;
    nrfd = 1'b1;
    ndac = 1'b1;
    // one idle edge so a following call never redrives in this time step
    @(posedge clock);
    #1;
  endtask
  task automatic get(output logic [7:0] b);
    nrfd = 1'b0;
    waitFor(2, 1'b1);
    b = dioBus;
    nrfd = 1'b1;
    ndac = 1'b0;
    waitFor(2, 1'b0);
    ndac = 1'b1;
    @(posedge clock);
    #1;
  endtask
endmodule

// file: test_gpib_device_status_port.sv
// self-checking bench for the instrument bus status port
// assumes gdsp_ctrl_model as bus controller, 25 MHz clock
`timescale 1ns/1ps
module test_gpib_device_status_port;
  import gdsp_pkg::*;
  logic clock, rst_n, busEnable, atnB, davB, nrfdB, ndacB, cAtn, cDav, cNrfd, cNdac, tmo;
  logic davOut, davOe, nrfdOut, nrfdOe, ndacOut, ndacOe, srqOut, srqOe, rxValid, dioOe;
  logic cmdValid, cmdReady, opsPending, localCopyReq, printToBus, remoteDisable;
  logic panelEnable, ctrlReq, devClear, devReset, talkAddr, listenAddr;
  logic [7:0] dioB, cDio, dioOut, rxData, cmdArg, eventSet, stbDevBits, rxLast, a, e;
  logic [7:0] eseValue, sreValue, esrValue;
  logic [4:0] myAddr;
  gdsp_cmd_t  cmdCode;
  int unsigned seed = 34;
  int n_errors, cmp_count, nClr, nRst, i;
  logic [7:0] rq[$];
  assign atnB = cAtn;
  assign davB = cDav | (davOe & davOut);
  assign nrfdB = cNrfd | (nrfdOe & nrfdOut);
  assign ndacB = cNdac | (ndacOe & ndacOut);
  assign dioB = cDio | (dioOe ? dioOut : 8'h00);
  gdsp_port #(.QDEPTH(16)) u_dut (.clock, .rst_n, .myAddr, .busEnable, .atnIn(atnB),
    .dioIn(dioB), .davIn(davB), .nrfdIn(nrfdB), .ndacIn(ndacB), .dioOut, .dioOe, .davOut,
    .davOe, .nrfdOut, .nrfdOe, .ndacOut, .ndacOe, .srqOut, .srqOe, .rxValid, .rxData,
    .cmdValid, .cmdCode, .cmdArg, .cmdReady, .eventSet, .opsPending, .stbDevBits,
    .localCopyReq, .printToBus, .remoteDisable, .panelEnable, .ctrlReq, .devClear,
    .devReset, .talkAddr, .listenAddr, .eseValue, .sreValue, .esrValue);
  gdsp_ctrl_model u_ctrl (.clock, .nrfdBus(nrfdB), .ndacBus(ndacB), .davBus(davB),
    .dioBus(dioB), .atn(cAtn), .dio(cDio), .dav(cDav), .nrfd(cNrfd), .ndac(cNdac), .tmo);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (rxValid) rxLast <= rxData;
    if (devClear) nClr <= nClr + 1;
    if (devReset) nRst <= nRst + 1;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    cmp_count++;
    if (s !== x) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  // waits for ready under a bound, then drops valid
  task automatic cmd(input gdsp_cmd_t c, input logic [7:0] v);
    int n;
    n = 0;
    cmdValid = 1'b1;
    cmdCode = c;
    cmdArg = v;
    while (cmdReady !== 1'b1 && n < 300) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    #1 cmdValid = 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic drain();
    logic [7:0] b;
    u_ctrl.send(8'h40 | {3'h0, myAddr}, 1'b1, 0);
    while (rq.size() > 0) begin
      u_ctrl.get(b);
      chk("reply", b, rq.pop_front());
    end
    u_ctrl.send(8'h5F, 1'b1, 0);
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
  initial begin
    {clock, rst_n, busEnable, cmdValid, opsPending, localCopyReq} = '0;
    {printToBus, remoteDisable, cmdArg, eventSet, stbDevBits, rxLast, nClr, nRst} = '0;
    cmdCode = GDSP_NONE;
    myAddr = 5'(rnd() % 8'd30 + 8'd1);
    busEnable = 1'b1;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    chk("regs", eseValue | sreValue | esrValue, 8'h00);
    stbDevBits = rnd() & 8'h8F;
    a = rnd();
    cmd(GDSP_SRE, a);
    // summary bit position is never enabled, reads back zero
    a = a & 8'hBF;
    chk("sre", sreValue, a);
    rq.push_back(stbDevBits | {1'b0, |(stbDevBits & a), 6'h00});
    cmd(GDSP_STBQ, 8'h00);
    e = rnd();
    cmd(GDSP_ESE, e);
    chk("ese", eseValue, e);
    rq.push_back(e);
    cmd(GDSP_ESEQ, 8'h00);
    rq.push_back(a);
    cmd(GDSP_SREQ, 8'h00);
    eventSet = rnd() | 8'h02;
    e = eventSet;
    @(posedge clock);
    #1 eventSet = 8'h00;
    rq.push_back(e);
    cmd(GDSP_ESRQ, 8'h00);
    chk("esr", esrValue, 8'h00);
    for (i = 0; i < 4; i++) rq.push_back(8'h41 + 8'(i));
    cmd(GDSP_IDNQ, 8'h00);
    rq.push_back(8'h31);
    cmd(GDSP_OPCQ, 8'h00);
    drain();
    chk("srq", srqOut, |(stbDevBits & a));
    chk("srqoe", srqOe, |(stbDevBits & a));
    u_ctrl.send(8'h18, 1'b1, 0);
    u_ctrl.send(8'h40 | {3'h0, myAddr}, 1'b1, 0);
    u_ctrl.get(e);
    chk("poll", e, stbDevBits | {1'b0, |(stbDevBits & a), 6'h00});
    u_ctrl.send(8'h19, 1'b1, 0);
    u_ctrl.send(8'h20 | {3'h0, myAddr}, 1'b1, 0);
    chk("listen", listenAddr, 8'h01);
    e = rnd();
    u_ctrl.send(e, 1'b0, 2);
    chk("rx", rxLast, e);
    u_ctrl.send(8'h40 | {3'h0, myAddr}, 1'b1, 1);
    chk("addr", {talkAddr, listenAddr}, 8'h02);
    u_ctrl.send(8'h20 | {3'h0, myAddr}, 1'b1, 0);
    chk("addr", {talkAddr, listenAddr}, 8'h01);
    u_ctrl.send(8'h14, 1'b1, 0);
    chk("clear", 8'(nClr), 8'h01);
    u_ctrl.send(8'h3F, 1'b1, 0);
    cmd(GDSP_OPC, 8'h00);
    chk("opcnow", esrValue, 8'h01);
    cmd(GDSP_CLS, 8'h00);
    chk("cls", esrValue, 8'h00);
    opsPending = 1'b1;
    cmd(GDSP_OPC, 8'h00);
    chk("opc", esrValue, 8'h00);
    opsPending = 1'b0;
    repeat (3) @(posedge clock);
    #1 chk("opc", esrValue, 8'h01);
    cmd(GDSP_CLS, 8'h00);
    chk("cls", esrValue, 8'h00);
    opsPending = 1'b1;
    cmd(GDSP_WAI, 8'h00);
    cmdValid = 1'b1;
    cmdCode = GDSP_TSTQ;
    repeat (4) @(posedge clock);
    #1 chk("held", cmdReady, 8'h00);
    opsPending = 1'b0;
    @(posedge clock);
    rq.push_back(8'h00);
    #1 cmd(GDSP_TSTQ, 8'h00);
    chk("tst", sreValue, a);
    chk("tstrst", 8'(nRst), 8'h00);
    drain();
    for (i = 0; i < 8; i++) begin
      {localCopyReq, printToBus, remoteDisable} = 3'(i);
      #10 chk("ctrl", {ctrlReq, panelEnable}, {6'h00, i[2] & i[1], !i[0]});
      @(posedge clock);
      #1;
    end
    busEnable = 1'b0;
    #10 chk("offbus", ctrlReq, 8'h00);
    chk("handshake", tmo, 8'h00);
    end_of_test();
  end
endmodule
